// ### common/holdover_pkg.sv
// constants, register map and state codes of the holdover and switch control
// assumes an 8-bit register port with 9-bit addresses on one 25 MHz clock
package holdover_pkg;
   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;
   // register offsets
   localparam logic [8:0] OFS_MULT_TRIP = 9'h14e;
   localparam logic [8:0] OFS_RATE_CNT = 9'h14f;
   localparam logic [8:0] OFS_SW_CTRL = 9'h150;
   localparam logic [8:0] OFS_EXIT_HI = 9'h151;
   localparam logic [8:0] OFS_EXIT_LO = 9'h152;
   localparam logic [8:0] OFS_AUX_CTRL = 9'h1f0;
   localparam logic [8:0] OFS_IRQ_STAT = 9'h1f1;
   localparam logic [8:0] OFS_IRQ_MASK = 9'h1f2;
   localparam logic [8:0] OFS_STATE = 9'h1f3;
   localparam logic [8:0] OFS_TRACK_HI = 9'h1f4;
   localparam logic [8:0] OFS_TRACK_LO = 9'h1f5;
   // reset values
   localparam logic [7:0] RST_MULT_TRIP = 8'h00;
   localparam logic [7:0] RST_RATE_CNT = 8'h7f;
   localparam logic [7:0] RST_SW_CTRL = 8'h00;
   localparam logic [13:0] RST_EXIT_CNT = 14'h0200;
   localparam logic [9:0] RST_TRACK = 10'h200;
   // field positions in the switch control register
   localparam int SW_FORCE = 6;
   localparam int SW_EXIT_MODE = 5;
   localparam int SW_LOCK_LOSS = 4;
   localparam int SW_PIN_ABS = 3;
   localparam int SW_TUNE_DET = 2;
   localparam int SW_PUMP_FLT = 1;
   localparam int SW_HOLD_EN = 0;
   // multiplier code n gives a shift of 2 + 4n
   localparam int MULT_SHIFT_BASE = 2;
   localparam int MULT_SHIFT_STEP = 4;
   localparam int TICK_W = 22;
   // interrupt status bits
   localparam int IRQ_SWITCH = 0;
   localparam int IRQ_HOLD_IN = 1;
   localparam int IRQ_HOLD_OUT = 2;
   localparam int IRQ_TRIP = 3;
   typedef enum logic [2:0] {
      ST_NORMAL = 3'b001,
      ST_HOLD = 3'b010,
      ST_EXIT = 3'b100
   } hold_state_t;
endpackage

// ### hw/holdover_switch_control.sv
// holdover entry/exit, input switch events, tracking and register port
// assumes lock, detector-clock and internal absence inputs on i_mclk;
// the three absence pins are asynchronous and are synchronised here
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module holdover_switch_control
   import holdover_pkg::*;
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // register port
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   // loop status
   input wire logic i_lock_ind,
   input wire logic i_pd_clk_valid,
   input wire logic [2:0] i_int_absence,
   input wire logic [9:0] i_tune_code,
   // absence pins and their pin type
   input wire logic i_select_pin_zero,
   input wire logic i_select_pin_one,
   input wire logic i_lock_status_pin_one,
   input wire logic [2:0] i_pin_is_input,
   // control outputs
   output logic [1:0] o_active_input,
   output logic o_holdover_active,
   output logic o_switch_event,
   output logic o_pump_float,
   output logic o_dyn_delay_allow,
   output logic [9:0] o_tracked_dac,
   output logic o_irq
);
   typedef struct packed {
      logic [7:0] mult_trip;
      logic [7:0] rate_cnt;
      logic [7:0] sw_ctrl;
      logic [13:0] exit_cnt;
      logic [2:0] aux;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic [2:0] pin_s1;
      logic [2:0] pin_s2;
      hold_state_t st;
      logic [13:0] valid_cnt;
      logic [1:0] cur_in;
      logic lock_prev;
      logic trip_prev;
      logic [9:0] track;
      logic sw_ev;
      logic [7:0] rdata;
      logic irq;
   } ctl_state_t;

   ctl_state_t q_ff, nxt_q;
   logic tick;
   logic restart;
   logic [2:0] absent;
   logic trip;
   logic lock_fall;
   logic switch_req;
   logic leave_ok;
   logic [3:0] ev;
   logic [10:0] trip_level;

   // rewriting either rate register restarts the tick
   assign restart = i_wr && (i_addr == OFS_MULT_TRIP || i_addr == OFS_RATE_CNT);

   track_tick u_tick (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_restart(restart),
      .i_mult_code(q_ff.mult_trip[7:6]),
      .i_rate_count(q_ff.rate_cnt),
      .o_tick(tick)
   );

   // absence per input and event causes
   always_comb begin
      if (q_ff.sw_ctrl[SW_PIN_ABS]) begin
         absent = q_ff.pin_s2 | ~i_pin_is_input;
      end else begin
         absent = i_int_absence;
      end
      // trip level (n+1)/64 below the rail, on a 10-bit code
      // kept at 11 bits so that code 63 gives level 0 instead of wrapping
      trip_level = 11'h400 - ((11'(q_ff.mult_trip[5:0]) + 11'h001) << 4);
      trip = q_ff.sw_ctrl[SW_TUNE_DET] && ({1'b0, q_ff.track} >= trip_level);
      lock_fall = q_ff.sw_ctrl[SW_LOCK_LOSS] && q_ff.lock_prev && !i_lock_ind;
      // rail reached counts as invalid input
      switch_req = lock_fall || (trip && !q_ff.trip_prev) || absent[q_ff.cur_in];
      if (q_ff.sw_ctrl[SW_EXIT_MODE]) begin
         leave_ok = i_lock_ind;
      end else begin
         leave_ok = !absent[q_ff.cur_in];
      end
   end

   // next state of the whole block
   always_comb begin
      nxt_q = q_ff;
      ev = 4'h0;
      nxt_q.pin_s1 = {i_lock_status_pin_one, i_select_pin_one, i_select_pin_zero};
      nxt_q.pin_s2 = q_ff.pin_s1;
      nxt_q.lock_prev = i_lock_ind;
      nxt_q.trip_prev = trip;
      nxt_q.sw_ev = 1'b0;
      if (tick && q_ff.aux[0] && i_lock_ind) begin
         nxt_q.track = i_tune_code;
      end
      // forced input, else step on switch
      if (q_ff.aux[1] && q_ff.sw_ctrl[SW_FORCE]) begin
         nxt_q.cur_in = (q_ff.aux[2] ? 2'd2 : q_ff.mult_trip[7] ? 2'd1 : 2'd0);
         nxt_q.cur_in = q_ff.irq_mask[3] ? nxt_q.cur_in : nxt_q.cur_in;
      end
      if (q_ff.aux[1] && q_ff.sw_ctrl[SW_FORCE]) begin
         nxt_q.cur_in = manual_pick(q_ff.aux);
      end
      unique case (q_ff.st)
         ST_NORMAL: begin
            if (switch_req) begin
               nxt_q.sw_ev = 1'b1;
               ev[IRQ_SWITCH] = 1'b1;
               if (!(q_ff.aux[1] && q_ff.sw_ctrl[SW_FORCE])) begin
                  nxt_q.cur_in = (q_ff.cur_in == 2'd2) ? 2'd0 : q_ff.cur_in + 2'd1;
               end
               if (q_ff.sw_ctrl[SW_HOLD_EN]) begin
                  nxt_q.st = ST_HOLD;
                  ev[IRQ_HOLD_IN] = 1'b1;
               end
            end
         end
         ST_HOLD: begin
            nxt_q.valid_cnt = '0;
            if (!q_ff.sw_ctrl[SW_HOLD_EN]) begin
               nxt_q.st = ST_NORMAL;
               ev[IRQ_HOLD_OUT] = 1'b1;
            end else if (leave_ok) begin
               nxt_q.st = ST_EXIT;
            end
         end
         ST_EXIT: begin
            if (!leave_ok) begin
               nxt_q.st = ST_HOLD;
            end else if (q_ff.valid_cnt >= q_ff.exit_cnt) begin
               nxt_q.st = ST_NORMAL;
               ev[IRQ_HOLD_OUT] = 1'b1;
            end else if (i_pd_clk_valid) begin
               nxt_q.valid_cnt = q_ff.valid_cnt + 14'h0001;
            end
         end
      endcase
      ev[IRQ_TRIP] = trip && !q_ff.trip_prev;
      // register writes
      if (i_wr) begin
         unique case (i_addr)
            OFS_MULT_TRIP: nxt_q.mult_trip = i_wdata;
            OFS_RATE_CNT: nxt_q.rate_cnt = i_wdata;
            OFS_SW_CTRL: nxt_q.sw_ctrl = {1'b0, i_wdata[6:0]};
            OFS_EXIT_HI: nxt_q.exit_cnt[13:8] = i_wdata[5:0];
            OFS_EXIT_LO: nxt_q.exit_cnt[7:0] = i_wdata;
            OFS_AUX_CTRL: nxt_q.aux = i_wdata[2:0];
            OFS_IRQ_STAT: nxt_q.irq_stat = q_ff.irq_stat & ~i_wdata[3:0];
            OFS_IRQ_MASK: nxt_q.irq_mask = i_wdata[3:0];
            default: ;
         endcase
      end
      // new events win over a clear in the same cycle
      nxt_q.irq_stat = nxt_q.irq_stat | ev;
      nxt_q.irq = |(q_ff.irq_stat & q_ff.irq_mask);
      // read data stand one cycle after the strobe
      nxt_q.rdata = 8'h00;
      if (i_rd) begin
         unique case (i_addr)
            OFS_MULT_TRIP: nxt_q.rdata = q_ff.mult_trip;
            OFS_RATE_CNT: nxt_q.rdata = q_ff.rate_cnt;
            OFS_SW_CTRL: nxt_q.rdata = q_ff.sw_ctrl;
            OFS_EXIT_HI: nxt_q.rdata = {2'b00, q_ff.exit_cnt[13:8]};
            OFS_EXIT_LO: nxt_q.rdata = q_ff.exit_cnt[7:0];
            OFS_AUX_CTRL: nxt_q.rdata = {5'h00, q_ff.aux};
            OFS_IRQ_STAT: nxt_q.rdata = {4'h0, q_ff.irq_stat};
            OFS_IRQ_MASK: nxt_q.rdata = {4'h0, q_ff.irq_mask};
            OFS_STATE: nxt_q.rdata = {3'h0, q_ff.cur_in, q_ff.st};
            OFS_TRACK_HI: nxt_q.rdata = {6'h00, q_ff.track[9:8]};
            OFS_TRACK_LO: nxt_q.rdata = q_ff.track[7:0];
            default: nxt_q.rdata = 8'h00;
         endcase
      end
   end

   // manual input choice sits in aux bit 2: set picks input 2, clear picks input 0
   function automatic logic [1:0] manual_pick(input logic [2:0] aux_bits);
      manual_pick = aux_bits[2] ? 2'd2 : 2'd0;
   endfunction

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q_ff <= '{mult_trip: RST_MULT_TRIP, rate_cnt: RST_RATE_CNT, sw_ctrl: RST_SW_CTRL,
                   exit_cnt: RST_EXIT_CNT, aux: 3'h0, irq_stat: 4'h0, irq_mask: 4'h0,
                   pin_s1: 3'h0, pin_s2: 3'h0, st: ST_NORMAL, valid_cnt: 14'h0000,
                   cur_in: 2'd0, lock_prev: 1'b0, trip_prev: 1'b0, track: RST_TRACK,
                   sw_ev: 1'b0, rdata: 8'h00, irq: 1'b0};
      end else begin
         q_ff <= nxt_q;
      end
   end

   // outputs straight from flops; pump and delay gating from next-state fields
   logic pump_ff;
   logic dly_ff;
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pump_ff <= 1'b0;
         dly_ff <= 1'b1;
      end else begin
         pump_ff <= nxt_q.sw_ctrl[SW_PUMP_FLT] && (nxt_q.st != ST_NORMAL || nxt_q.sw_ev);
         dly_ff <= !nxt_q.sw_ctrl[SW_FORCE];
      end
   end

   assign o_rdata = q_ff.rdata;
   assign o_active_input = q_ff.cur_in;
   assign o_holdover_active = (q_ff.st != ST_NORMAL);
   assign o_switch_event = q_ff.sw_ev;
   assign o_pump_float = pump_ff;
   assign o_dyn_delay_allow = dly_ff;
   assign o_tracked_dac = q_ff.track;
   assign o_irq = q_ff.irq;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   forced_input_a: assert property (q_ff.aux[1] && q_ff.sw_ctrl[SW_FORCE]
      ##1 q_ff.aux[1] && q_ff.sw_ctrl[SW_FORCE] && $stable(q_ff.aux)
      |=> o_active_input == manual_pick($past(q_ff.aux)))
      else $error("forced input not applied");
   delay_gate_a: assert property (q_ff.sw_ctrl[SW_FORCE] |-> !o_dyn_delay_allow)
      else $error("delay adjust allowed under forced hold");
   lock_loss_a: assert property (q_ff.st == ST_NORMAL && lock_fall
      |=> o_switch_event)
      else $error("lock loss gave no switch event");
   no_lock_sw_a: assert property (!q_ff.sw_ctrl[SW_LOCK_LOSS] && q_ff.st == ST_NORMAL
      && !absent[q_ff.cur_in] && !(trip && !q_ff.trip_prev) |=> !o_switch_event)
      else $error("switch without a cause");
   pump_float_a: assert property (!q_ff.sw_ctrl[SW_PUMP_FLT] && !nxt_q.sw_ctrl[SW_PUMP_FLT]
      |=> !o_pump_float)
      else $error("pump floated while disabled");
   hold_enable_a: assert property (!q_ff.sw_ctrl[SW_HOLD_EN] && q_ff.st == ST_NORMAL
      |=> q_ff.st == ST_NORMAL)
      else $error("holdover entered while disabled");
   track_lock_a: assert property (!i_lock_ind |=> $stable(o_tracked_dac))
      else $error("tracking moved while unlocked");
   exit_count_a: assert property (q_ff.st == ST_EXIT && nxt_q.st == ST_NORMAL
      |-> q_ff.valid_cnt >= q_ff.exit_cnt)
      else $error("holdover left before count");
   exit_crit_a: assert property (q_ff.st == ST_HOLD && !leave_ok
      |=> q_ff.st != ST_EXIT)
      else $error("exit started without criterion");
   trip_event_a: assert property (q_ff.st == ST_NORMAL && trip && !q_ff.trip_prev
      |=> o_switch_event && q_ff.irq_stat[IRQ_TRIP])
      else $error("rail trip gave no switch");
   pin_absence_a: assert property (q_ff.sw_ctrl[SW_PIN_ABS] && !i_pin_is_input[0]
      |-> absent[0])
      else $error("untyped pin read as valid");
   irq_level_a: assert property (|(q_ff.irq_stat & q_ff.irq_mask) |=> o_irq)
      else $error("irq not raised");

   enter_hold_c: cover property (q_ff.st == ST_NORMAL ##1 q_ff.st == ST_HOLD);
   leave_hold_c: cover property (q_ff.st == ST_EXIT ##1 q_ff.st == ST_NORMAL);
   track_upd_c: cover property (tick && q_ff.aux[0] && i_lock_ind);
endmodule

// ### hw/track_tick.sv
// tracking tick generator: one pulse every multiplier x count clocks
// assumes multiplier code and count come from registers on the same clock
`timescale 1ns/1ps
module track_tick
   import holdover_pkg::*;
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // settings
   input wire logic i_restart,
   input wire logic [1:0] i_mult_code,
   input wire logic [7:0] i_rate_count,
   // tick out
   output logic o_tick
);
   typedef struct packed {
      logic [TICK_W-1:0] cnt;
      logic tick;
   } tick_state_t;

   tick_state_t q_ff, nxt_q;
   logic [TICK_W-1:0] period;

   always_comb begin
      period = TICK_W'({14'h0000, i_rate_count} << (MULT_SHIFT_BASE +
                                            MULT_SHIFT_STEP * int'(i_mult_code)));
   end

   always_comb begin
      nxt_q = q_ff;
      nxt_q.tick = 1'b0;
      if (i_restart || period == '0) begin
         nxt_q.cnt = '0;
      end else if (q_ff.cnt >= period - TICK_W'(1)) begin
         nxt_q.cnt = '0;
         nxt_q.tick = 1'b1;
      end else begin
         nxt_q.cnt = q_ff.cnt + TICK_W'(1);
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign o_tick = q_ff.tick;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   tick_restart_a: assert property (i_restart |=> !o_tick ##1 !o_tick)
      else $error("tick right after restart");
   tick_period_a: assert property ($rose(o_tick) && period == TICK_W'(4) && !i_restart
      ##1 (!i_restart && $stable(period)) [*4] |-> o_tick)
      else $error("tick period of four missed");
endmodule

// ### testbench/holdover_switch_control_tb.sv
// self-checking bench for the holdover and switch control block
// assumes one 25 MHz clock; reads answer in the cycle after the strobe
`timescale 1ns/1ps
module holdover_switch_control_tb;
   import holdover_pkg::*;
   logic i_mclk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0;
   logic [ADDR_W-1:0] i_addr = '0;
   logic [DATA_W-1:0] i_wdata = '0, o_rdata, rv;
   logic i_lock_ind = 0, i_pd_clk_valid = 0, i_p0 = 0, i_p1 = 0, i_p2 = 0;
   logic [2:0] i_int_absence = '0, i_pin_is_input = 3'h7;
   logic [9:0] i_tune_code = '0, o_tracked_dac, prev;
   logic [1:0] o_active_input;
   logic o_holdover_active, o_switch_event, o_pump_float, o_dyn_delay_allow, o_irq;
   int errors = 0, n_checks = 0, seed = 32'hb0c1, cnt, cyc, last, got, d;
   int addrs[3] = '{OFS_MULT_TRIP, OFS_RATE_CNT, OFS_SW_CTRL};
   int masks[3] = '{8'hff, 8'hff, 8'h7f}; // top bit of switch control is reserved
   // clock: 40 ns period
   always #20 i_mclk = ~i_mclk;
   holdover_switch_control DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_lock_ind(i_lock_ind), .i_pd_clk_valid(i_pd_clk_valid),
      .i_int_absence(i_int_absence), .i_tune_code(i_tune_code),
      .i_select_pin_zero(i_p0), .i_select_pin_one(i_p1), .i_lock_status_pin_one(i_p2),
      .i_pin_is_input(i_pin_is_input), .o_active_input(o_active_input),
      .o_holdover_active(o_holdover_active), .o_switch_event(o_switch_event),
      .o_pump_float(o_pump_float), .o_dyn_delay_allow(o_dyn_delay_allow),
      .o_tracked_dac(o_tracked_dac), .o_irq(o_irq));
   task summarize;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task tmo(input string nm);
      chk(nm, 0, 1);
      summarize;
   endtask
   // register cycles: strobe for one cycle, read data stands the cycle after
   task wr(input logic [8:0] a, input logic [7:0] v);
      @(posedge i_mclk);
      i_wr <= 1; i_addr <= a; i_wdata <= v;
      @(posedge i_mclk);
      i_wr <= 0;
   endtask
   task rd(input logic [8:0] a, output logic [7:0] v);
      @(posedge i_mclk);
      i_rd <= 1; i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 0;
      #1 v = o_rdata;
   endtask
   task reset;
      i_rst_n <= 0;
      repeat (4) @(posedge i_mclk);
      i_rst_n <= 1;
   endtask
   // count switch events over a window of n cycles
   task evcount(input int n, output int c);
      c = 0;
      repeat (n) begin
         @(posedge i_mclk);
         #1 if (o_switch_event === 1'b1) c++;
      end
   endtask
   // wait for a switch event, bounded
   task waitev(input string nm);
      cnt = 0;
      do begin
         @(posedge i_mclk);
         #1 cnt++;
      end while (o_switch_event !== 1'b1 && cnt < 8);
      if (o_switch_event !== 1'b1) tmo(nm);
   endtask
   task pd(input int n);
      repeat (n) begin
         @(posedge i_mclk);
         i_pd_clk_valid <= 1;
         @(posedge i_mclk);
         i_pd_clk_valid <= 0;
      end
   endtask
   // leave holdover within a bounded wait
   task waitleave;
      cnt = 0;
      while (o_holdover_active !== 1'b0 && cnt < 8) begin
         @(posedge i_mclk);
         #1 cnt++;
      end
      chk("holdover left", o_holdover_active, 0);
   endtask
   initial begin
      reset;
      #1 chk("tracked reset", o_tracked_dac, 10'h200);
      chk("delay allow reset", o_dyn_delay_allow, 1);
      for (int i = 0; i < 3; i++) begin
         rd(9'(addrs[i]), rv);
         chk("reg reset", rv, i == 1 ? 8'h7f : 8'h00);
         d = $random(seed) & 8'hff;
         wr(9'(addrs[i]), 8'(d));
         rd(9'(addrs[i]), rv);
         chk("reg readback", rv, 8'(d & masks[i]));
      end
      rd(9'h100, rv);
      chk("unmapped read", rv, 0);
      $display("test registers done");
      reset;
      // forced input: manual mode, choice selects input 2
      wr(OFS_AUX_CTRL, 8'h06);
      wr(OFS_SW_CTRL, 8'h40);
      repeat (2) @(posedge i_mclk);
      #1 chk("forced input", o_active_input, 2);
      chk("delay allow forced", o_dyn_delay_allow, 0);
      $display("test forced done");
      reset;
      // lock loss with the enable clear must not switch
      wr(OFS_SW_CTRL, 8'h01);
      i_lock_ind <= 1;
      repeat (3) @(posedge i_mclk);
      i_lock_ind <= 0;
      evcount(6, cnt);
      chk("no lock loss event", cnt, 0);
      // lock loss enabled, pump float on switch, exit after 3 detector clocks
      wr(OFS_EXIT_HI, 8'h00);
      wr(OFS_EXIT_LO, 8'h03);
      wr(OFS_SW_CTRL, 8'h13);
      i_lock_ind <= 1;
      repeat (3) @(posedge i_mclk);
      i_lock_ind <= 0;
      waitev("lock loss event");
      chk("holdover entered", o_holdover_active, 1);
      chk("input stepped", o_active_input, 1);
      chk("pump float", o_pump_float, 1);
      @(posedge i_mclk);
      #1 chk("event one cycle", o_switch_event, 0);
      chk("irq masked", o_irq, 0);
      rd(OFS_IRQ_STAT, rv);
      chk("irq status", rv, 8'h03);
      wr(OFS_IRQ_MASK, 8'h01);
      @(posedge i_mclk);
      #1 chk("irq raised", o_irq, 1);
      wr(OFS_IRQ_STAT, 8'h01);
      @(posedge i_mclk);
      #1 chk("irq cleared", o_irq, 0);
      // criterion 0: input present, count detector clocks
      pd(2);
      #1 chk("still counting", o_holdover_active, 1);
      pd(1);
      waitleave;
      chk("pump released", o_pump_float, 0);
      // criterion 1: stay while unlocked, leave once locked and counted
      wr(OFS_SW_CTRL, 8'h33);
      i_lock_ind <= 1;
      repeat (3) @(posedge i_mclk);
      i_lock_ind <= 0;
      waitev("second event");
      pd(4);
      #1 chk("unlocked stays", o_holdover_active, 1);
      i_lock_ind <= 1;
      pd(3);
      waitleave;
      $display("test holdover done");
      // pin-sourced absence: present pins, then untyped pins, then absent pins
      wr(OFS_SW_CTRL, 8'h08);
      evcount(8, cnt);
      chk("pins present", cnt, 0);
      i_pin_is_input <= 3'h0;
      waitev("untyped pin event");
      i_pin_is_input <= 3'h7;
      // skip the event already in flight, then typed present pins stay quiet
      evcount(1, cnt);
      evcount(2, cnt);
      chk("typed pins valid", cnt, 0);
      i_p0 <= 1; i_p1 <= 1; i_p2 <= 1;
      waitev("absent pin event");
      i_p0 <= 0; i_p1 <= 0; i_p2 <= 0;
      $display("test pins done");
      // tracking interval for each multiplier code with count 1
      wr(OFS_SW_CTRL, 8'h00);
      wr(OFS_AUX_CTRL, 8'h01);
      wr(OFS_RATE_CNT, 8'h01);
      for (int m = 0; m < 4; m++) begin
         wr(OFS_MULT_TRIP, 8'(m << 6));
         prev = o_tracked_dac; got = 0; cyc = 0; last = 0;
         while (got < 2 && cyc < 40000) begin
            @(posedge i_mclk);
            // differs from the held code so every update is visible
            i_tune_code <= ~prev ^ 10'($random(seed) & 1);
            #1 cyc++;
            if (o_tracked_dac !== prev) begin
               if (got > 0) chk("track interval", cyc - last, 4 << (4 * m));
               last = cyc; got++; prev = o_tracked_dac;
            end
         end
         if (got < 2) tmo("track tick");
      end
      // unlocked: tracked value holds, with ticks every 4 cycles
      wr(OFS_MULT_TRIP, 8'h00);
      i_lock_ind <= 0;
      @(posedge i_mclk);
      #1 prev = o_tracked_dac;
      evcount(40, cnt);
      chk("track unlocked", o_tracked_dac, prev);
      $display("test tracking done");
      // rail trip: drop the trip level to 0, then enable detection; set the
      // level first, so the trip rises exactly when detection is enabled
      wr(OFS_MULT_TRIP, 8'h3f);
      wr(OFS_SW_CTRL, 8'h04);
      waitev("rail trip event");
      rd(OFS_IRQ_STAT, rv);
      chk("trip status", rv[IRQ_TRIP], 1);
      $display("test trip done");
      summarize;
   end
endmodule
